//--- rtl/phy_nextpage_params.svh
// Offsets, field positions, reset values and widths for the next-page register bank
`ifndef PHY_NEXTPAGE_PARAMS_SVH
`define PHY_NEXTPAGE_PARAMS_SVH

`define ADDR_EXPANSION        5'h06
`define ADDR_LOCAL_NEXT_PAGE  5'h07
`define ADDR_PARTNER_NP       5'h08
`define ADDR_DIGITAL_SPARE    5'h10
`define ADDR_ANALOG_FE_CTRL_ONE 5'h11
`define ADDR_RX_SYMERR_COUNT  5'h15

`define EXP_NP_ABLE_BIT       2
`define EXP_PAGE_RCVD_BIT     1
`define EXP_LP_AN_ABLE_BIT    0

`define NP_MSG_PAGE_BIT       13
`define NP_ACK2_BIT           12
`define NP_TOGGLE_BIT         11
`define NP_NEXT_PAGE_BIT      15
`define NP_ACK_BIT            14

`define PLL_OFF_BIT           4
`define SLOW_OSC_BIT          5

`define LOCAL_MSG_PAGE_RST    1'h1
`define LOCAL_ACK2_RST        1'h0
`define LOCAL_MSG_CODE_RST    11'h001
`define DIGITAL_SPARE_RST     16'h0000
`define ANALOG_FE_CTRL_ONE_RST 16'h0000
`define SYMERR_COUNT_RST      16'h0000

`define MSG_CODE_W            11
`define REG_W                 16

`endif

//--- rtl/phy_nextpage_pkg.sv
// Types shared by the next-page register bank
package phy_nextpage_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [4:0]  reg_addr_t;
endpackage

//--- rtl/latch_high_bit.sv
// Latching-high status bit that clears on read unless its cause persists
`timescale 1ns/1ps
`include "phy_nextpage_params.svh"
module latch_high_bit (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic set_evt,
  input  wire logic read_clr,
  output logic      flag
);
  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (read_clr) begin
      flag_d = 1'h0;
    end
    if (set_evt) begin
      flag_d = 1'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flag_q <= 1'h0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule

//--- rtl/phy_autoneg_nextpage_regs.sv
// Auto-negotiation next-page, power control and symbol-error counter registers
//
// Function
// - Expansion bit 2 reports local next-page capability, read-only, reading one.
// - Expansion bit 1 latches high when a new page arrives from the partner.
// - Expansion bit 0 shows partner auto-negotiation ability, read-only, reset zero.
// - Local next page holds writable message-page (reset one) and ack2 (reset zero) bits.
// - Local next page toggle bit is read-only, tracks the last sent word, reset zero.
// - Local next page holds a writable 11-bit message code reset to 001h.
// - Partner page next-page, ack and 11-bit message are captured read-only, reset zero.
// - Partner page-type and ack2 bits are exposed read-only, reset zero.
// - Partner toggle bit is reported read-only.
// - A writable bit lets the PLL stop during energy-detect power-down; clear keeps it on.
// - Slow-oscillator mode also forces analog front-end power-down.
// - A 16-bit counter counts symbol-error frames and clears when read.
`timescale 1ns/1ps
`include "phy_nextpage_params.svh"
module phy_autoneg_nextpage_regs #(
  parameter int CNT_W = `REG_W
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  // Management register port
  input  wire phy_nextpage_pkg::reg_addr_t reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire phy_nextpage_pkg::reg_word_t reg_wdata,
  output phy_nextpage_pkg::reg_word_t      reg_rdata,
  // Auto-negotiation engine side
  input  wire logic                        partner_an_able,
  input  wire logic                        page_rcvd_evt,
  input  wire phy_nextpage_pkg::reg_word_t partner_page,
  input  wire logic                        np_word_sent,
  input  wire logic                        np_sent_toggle,
  output logic                             local_msg_page,
  output logic                             local_ack2,
  output logic [`MSG_CODE_W-1:0]           local_msg_code,
  // Power control
  input  wire logic                        energy_detect_power_down,
  output logic                             pll_stop,
  output logic                             crystal_input_pin_disconnect,
  output logic                             slow_osc_select,
  output logic                             analog_frontend_power_down,
  // Receive symbol errors
  input  wire logic                        rx_symbol_error_frame
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic                        msg_page_q;
  logic                        msg_page_d;
  logic                        ack2_q;
  logic                        ack2_d;
  logic                        toggle_q;
  logic                        toggle_d;
  logic [`MSG_CODE_W-1:0]      msg_code_q;
  logic [`MSG_CODE_W-1:0]      msg_code_d;
  phy_nextpage_pkg::reg_word_t partner_q;
  phy_nextpage_pkg::reg_word_t partner_d;
  phy_nextpage_pkg::reg_word_t dig_q;
  phy_nextpage_pkg::reg_word_t dig_d;
  phy_nextpage_pkg::reg_word_t ana_q;
  phy_nextpage_pkg::reg_word_t ana_d;
  logic [CNT_W-1:0]            cnt_q;
  logic [CNT_W-1:0]            cnt_d;
  logic                        an_able_q;
  logic                        an_able_d;
  phy_nextpage_pkg::reg_word_t rdata_q;
  phy_nextpage_pkg::reg_word_t rdata_d;
  logic                        page_rcvd;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic                        wr_local;
  logic                        wr_dig;
  logic                        wr_ana;
  logic                        rd_exp;
  logic                        rd_cnt;

  assign wr_local = reg_wr && (reg_addr == `ADDR_LOCAL_NEXT_PAGE);
  assign wr_dig   = reg_wr && (reg_addr == `ADDR_DIGITAL_SPARE);
  assign wr_ana   = reg_wr && (reg_addr == `ADDR_ANALOG_FE_CTRL_ONE);
  assign rd_exp   = reg_rd && (reg_addr == `ADDR_EXPANSION);
  assign rd_cnt   = reg_rd && (reg_addr == `ADDR_RX_SYMERR_COUNT);

  // ----------------------------------------
  // Latching-high page-received flag
  // ----------------------------------------
  latch_high_bit u_page_rcvd (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_evt  (page_rcvd_evt),
    .read_clr (rd_exp),
    .flag     (page_rcvd)
  );

  // ----------------------------------------
  // Next page, partner capture and power control
  // ----------------------------------------
  always_comb begin
    msg_page_d = msg_page_q;
    ack2_d     = ack2_q;
    toggle_d   = toggle_q;
    msg_code_d = msg_code_q;
    partner_d  = partner_q;
    dig_d      = dig_q;
    ana_d      = ana_q;
    an_able_d  = partner_an_able;
    if (wr_local) begin
      msg_page_d = reg_wdata[`NP_MSG_PAGE_BIT];
      ack2_d     = reg_wdata[`NP_ACK2_BIT];
      msg_code_d = reg_wdata[`MSG_CODE_W-1:0];
    end
    if (wr_dig) begin
      dig_d = reg_wdata;
    end
    if (wr_ana) begin
      ana_d = reg_wdata;
    end
    if (np_word_sent) begin
      toggle_d = np_sent_toggle;
    end
    if (page_rcvd_evt) begin
      partner_d = partner_page;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      msg_page_q <= `LOCAL_MSG_PAGE_RST;
      ack2_q     <= `LOCAL_ACK2_RST;
      toggle_q   <= 1'h0;
      msg_code_q <= `LOCAL_MSG_CODE_RST;
      partner_q  <= 16'h0000;
      dig_q      <= `DIGITAL_SPARE_RST;
      ana_q      <= `ANALOG_FE_CTRL_ONE_RST;
      an_able_q  <= 1'h0;
    end else begin
      msg_page_q <= msg_page_d;
      ack2_q     <= ack2_d;
      toggle_q   <= toggle_d;
      msg_code_q <= msg_code_d;
      partner_q  <= partner_d;
      dig_q      <= dig_d;
      ana_q      <= ana_d;
      an_able_q  <= an_able_d;
    end
  end

  // ----------------------------------------
  // Symbol-error frame counter
  // ----------------------------------------
  // Read clears the count; an error in the same cycle still counts; the count saturates
  always_comb begin
    cnt_d = cnt_q;
    if (rd_cnt) begin
      cnt_d = '0;
    end
    if (rx_symbol_error_frame && (cnt_d != {CNT_W{1'h1}})) begin
      cnt_d = cnt_d + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q <= CNT_W'(`SYMERR_COUNT_RST);
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_EXPANSION: begin
          rdata_d = 16'h0000;
          rdata_d[`EXP_NP_ABLE_BIT]    = 1'h1;
          rdata_d[`EXP_PAGE_RCVD_BIT]  = page_rcvd;
          rdata_d[`EXP_LP_AN_ABLE_BIT] = an_able_q;
        end
        `ADDR_LOCAL_NEXT_PAGE: begin
          rdata_d = {2'h0, msg_page_q, ack2_q, toggle_q, msg_code_q};
        end
        `ADDR_PARTNER_NP: begin
          rdata_d = partner_q;
        end
        `ADDR_DIGITAL_SPARE: begin
          rdata_d = dig_q;
        end
        `ADDR_ANALOG_FE_CTRL_ONE: begin
          rdata_d = ana_q;
        end
        `ADDR_RX_SYMERR_COUNT: begin
          rdata_d = cnt_q[`REG_W-1:0];
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata                    = rdata_q;
  assign local_msg_page               = msg_page_q;
  assign local_ack2                   = ack2_q;
  assign local_msg_code               = msg_code_q;
  assign pll_stop                     = dig_q[`PLL_OFF_BIT] & energy_detect_power_down;
  assign slow_osc_select              = ana_q[`SLOW_OSC_BIT];
  assign crystal_input_pin_disconnect = ana_q[`SLOW_OSC_BIT];
  assign analog_frontend_power_down   = ana_q[`SLOW_OSC_BIT];
endmodule

//--- verification/nextpage_props.sv
// Port checks for the next-page register bank
`timescale 1ns/1ps
module nextpage_props #(parameter int CNT_W = 16) (
  input logic        core_clk,
  input logic        rst_b,
  input logic [4:0]  reg_addr,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input logic        page_rcvd_evt,
  input logic [15:0] partner_page,
  input logic [10:0] local_msg_code,
  input logic        energy_detect_power_down,
  input logic        pll_stop,
  input logic        slow_osc_select,
  input logic        analog_frontend_power_down,
  input logic        rx_symbol_error_frame
);
  logic [15:0] page_q;
  logic        seen_q;
  wire         rd6 = reg_rd && reg_addr == 5'h06;
  wire         rd15 = reg_rd && reg_addr == 5'h15 && !rx_symbol_error_frame;
  // Reference copy of the page flag and the captured partner word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      page_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (page_rcvd_evt) begin
      page_q <= partner_page;
      seen_q <= 1'b1;
    end else if (rd6) begin
      seen_q <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  pll_gate_a:
  assert property (pll_stop |-> energy_detect_power_down) else $error("pll stop early");
  osc_power_a:
  assert property (analog_frontend_power_down == slow_osc_select) else $error("analog power");
  msg_write_a:
  assert property (reg_wr && reg_addr == 5'h07 |=> local_msg_code == 11'($past(reg_wdata))) else $error("msg code");
  np_able_a:
  assert property (rd6 |=> reg_rdata[2]) else $error("np able low");
  page_set_a:
  assert property (rd6 && seen_q |=> reg_rdata[1]) else $error("page flag lost");
  flag_clear_a:
  assert property (rd6 && !seen_q && !page_rcvd_evt |=> !reg_rdata[1]) else $error("page flag stuck");
  page_copy_a:
  assert property (reg_rd && reg_addr == 5'h08 && !page_rcvd_evt |=> reg_rdata == page_q) else $error("page word");
  count_clear_a:
  assert property (rd15 ##1 !rx_symbol_error_frame ##1 rd15 |=> reg_rdata == 16'h0000) else $error("count kept");
endmodule
bind phy_autoneg_nextpage_regs nextpage_props #(.CNT_W(CNT_W)) props_i (
  .core_clk                   (core_clk),
  .rst_b                      (rst_b),
  .reg_addr                   (reg_addr),
  .reg_wr                     (reg_wr),
  .reg_rd                     (reg_rd),
  .reg_wdata                  (reg_wdata),
  .reg_rdata                  (reg_rdata),
  .page_rcvd_evt              (page_rcvd_evt),
  .partner_page               (partner_page),
  .local_msg_code             (local_msg_code),
  .energy_detect_power_down   (energy_detect_power_down),
  .pll_stop                   (pll_stop),
  .slow_osc_select            (slow_osc_select),
  .analog_frontend_power_down (analog_frontend_power_down),
  .rx_symbol_error_frame      (rx_symbol_error_frame)
);

//--- verification/mgmt_model.sv
// Management controller model for the register port
`timescale 1ns/1ps
module mgmt_model (
  input  logic        core_clk,
  output logic [4:0]  reg_addr,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic [15:0] reg_wdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 23'h0;
  // One strobe per access; released address and data lines show the inverse of their last value, strobes return low
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, ~w};
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'h0};
  endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the next-page register bank
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0, rst_b = 1'b0;
  logic        reg_wr, reg_rd, pll_stop, local_msg_page, local_ack2, partner_an_able;
  logic        page_rcvd_evt, np_word_sent, np_sent_toggle, rx_symbol_error_frame;
  logic        energy_detect_power_down, crystal_input_pin_disconnect;
  logic        slow_osc_select, analog_frontend_power_down;
  logic [10:0] local_msg_code;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, partner_page, v, w, exp_q[$];
  int          n_errors = 0, tests_run = 0, seed = 52925;
  always #20 core_clk = ~core_clk;
  phy_autoneg_nextpage_regs uut (
    .core_clk                     (core_clk),
    .rst_b                        (rst_b),
    .reg_addr                     (reg_addr),
    .reg_wr                       (reg_wr),
    .reg_rd                       (reg_rd),
    .reg_wdata                    (reg_wdata),
    .reg_rdata                    (reg_rdata),
    .partner_an_able              (partner_an_able),
    .page_rcvd_evt                (page_rcvd_evt),
    .partner_page                 (partner_page),
    .np_word_sent                 (np_word_sent),
    .np_sent_toggle               (np_sent_toggle),
    .local_msg_page               (local_msg_page),
    .local_ack2                   (local_ack2),
    .local_msg_code               (local_msg_code),
    .energy_detect_power_down     (energy_detect_power_down),
    .pll_stop                     (pll_stop),
    .crystal_input_pin_disconnect (crystal_input_pin_disconnect),
    .slow_osc_select              (slow_osc_select),
    .analog_frontend_power_down   (analog_frontend_power_down),
    .rx_symbol_error_frame        (rx_symbol_error_frame)
  );
  mgmt_model mgmt (
    .core_clk  (core_clk),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata)
  );
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    mgmt.acc(1'b0, a, 16'h0000);
  endtask
  task automatic pulse(input logic [2:0] s);
    {page_rcvd_evt, np_word_sent, rx_symbol_error_frame} = s;
    @(negedge core_clk);
    {page_rcvd_evt, np_word_sent, rx_symbol_error_frame} = 3'h0;
    @(negedge core_clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (reg_rd === 1'b1) begin
      @(negedge core_clk);
      chk(reg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    #20000;
    n_errors++;
    close_out();
  end
  initial begin
    {partner_an_able, np_sent_toggle, energy_detect_power_down, partner_page} = 19'h0;
    {page_rcvd_evt, np_word_sent, rx_symbol_error_frame} = 3'h0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    rd(5'h06, 16'h0004);
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h0000);
    rd(5'h10, 16'h0000);
    rd(5'h11, 16'h0000);
    rd(5'h15, 16'h0000);
    $display("test reset values done");
    v = 16'($random(seed));
    mgmt.acc(1'b1, 5'h07, v);
    chk({2'h0, local_msg_page, local_ack2, 1'b0, local_msg_code}, v & 16'h37FF);
    mgmt.acc(1'b1, 5'h08, v);
    mgmt.acc(1'b1, 5'h1F, v);
    rd(5'h08, 16'h0000);
    rd(5'h1F, 16'h0000);
    $display("test writes done");
    w = 16'($random(seed));
    {partner_an_able, partner_page, np_sent_toggle} = {1'b1, w, 1'b1};
    pulse(3'h6);
    partner_page = ~w;
    rd(5'h06, 16'h0007);
    rd(5'h06, 16'h0005);
    rd(5'h08, w);
    rd(5'h07, v & 16'h37FF | 16'h0800);
    $display("test pages done");
    mgmt.acc(1'b1, 5'h10, 16'h0010);
    rd(5'h10, 16'h0010);
    energy_detect_power_down = 1'b1;
    #1 chk({15'h0, pll_stop}, 16'h0001);
    mgmt.acc(1'b1, 5'h10, 16'h0000);
    chk({15'h0, pll_stop}, 16'h0000);
    mgmt.acc(1'b1, 5'h11, 16'h0020);
    chk({13'h0, crystal_input_pin_disconnect, slow_osc_select, analog_frontend_power_down}, 16'h0007);
    rd(5'h11, 16'h0020);
    $display("test power done");
    repeat (5) pulse(3'h1);
    rd(5'h15, 16'h0005);
    rd(5'h15, 16'h0000);
    @(negedge core_clk);
    $display("test errors done");
    close_out();
  end
endmodule
